//--- logic/sqsp_pkg.sv
// Summary of operation
// - Sample every input lane on the serial clock rise.
// - Launch output lanes on the serial clock fall.
// - Accept a serial clock idling low or high.
// - Select high: ignore lanes, outputs undriven.
// - Instruction: eight bits on lane zero, on all four lanes in all-quad.
// - Two address bytes follow each read or write.
// - Low fourteen address bits form a byte address.
// - Address bits 15:14: 10b decrements, 01b increments.
// - Other step codes keep the word address fixed.
// - Lanes stay undriven during dummy byte cycles.
// - One or more 32-bit words follow.
// - Code 38h enters all-quad, FFh leaves it.
// - Instruction and address sent most significant first.
// - Data words little endian, msb first per byte.
// - 03h plain read, 0Bh fast read with one dummy, three in all-quad.
// - 3Bh and 6Bh return data on two or four lanes.
// - BBh and EBh: wide address, two or four dummies.
// - 02h plain write, all single lane; all four lanes in all-quad.
// - 32h and 62h write data on two or four lanes.
// - B2h and E2h send address and data wide.
// - All-quad mode: leave, fast read, write only.
// - Words continue at stepped address while selected.
// - First read bit launched on fall after last dummy, or last address bit for 03h.
package sqsp_pkg;

	// Instruction codes.
	localparam logic [7:0] CMD_READ        = 8'h03;
	localparam logic [7:0] CMD_FAST_RD     = 8'h0b;
	localparam logic [7:0] CMD_DUAL_OUT_RD = 8'h3b;
	localparam logic [7:0] CMD_DUAL_IO_RD  = 8'hbb;
	localparam logic [7:0] CMD_QUAD_OUT_RD = 8'h6b;
	localparam logic [7:0] CMD_QUAD_IO_RD  = 8'heb;
	localparam logic [7:0] CMD_WRITE       = 8'h02;
	localparam logic [7:0] CMD_DUAL_DATA_WR = 8'h32;
	localparam logic [7:0] CMD_DUAL_ADDR_WR = 8'hb2;
	localparam logic [7:0] CMD_QUAD_DATA_WR = 8'h62;
	localparam logic [7:0] CMD_QUAD_ADDR_WR = 8'he2;
	localparam logic [7:0] CMD_ENTER_QUAD  = 8'h38;
	localparam logic [7:0] CMD_LEAVE_QUAD  = 8'hff;

	// Field lengths in bits, at the width of the bit counter.
	localparam logic [5:0] CMD_BITS   = 6'h08;
	localparam logic [5:0] ADDR_BITS  = 6'h10;
	localparam logic [5:0] FIRE_BITS  = 6'h0e;
	localparam logic [5:0] WORD_BITS  = 6'h20;

	// Lane widths per clock and the matching output enables.
	localparam logic [2:0] LW1   = 3'h1;
	localparam logic [2:0] LW2   = 3'h2;
	localparam logic [2:0] LW4   = 3'h4;
	localparam logic [3:0] OE_W1 = 4'h2;
	localparam logic [3:0] OE_W2 = 4'h3;
	localparam logic [3:0] OE_W4 = 4'hf;

	// Dummy bytes per instruction.
	localparam logic [2:0] DUMMY_NONE = 3'h0;
	localparam logic [2:0] DUMMY_ONE  = 3'h1;
	localparam logic [2:0] DUMMY_DIO  = 3'h2;
	localparam logic [2:0] DUMMY_ALLQ = 3'h3;
	localparam logic [2:0] DUMMY_QIO  = 3'h4;

	// Address step field and word address layout.
	localparam logic [1:0]  STEP_INC  = 2'h1;
	localparam logic [1:0]  STEP_DEC  = 2'h2;
	localparam logic [11:0] ADDR_STEP = 12'h001;
	localparam logic [1:0]  BYTE_LSBS = 2'h0;

	typedef struct packed {
		logic       valid;
		logic       rd;
		logic [2:0] aw;
		logic [2:0] dw;
		logic [2:0] dummy;
	} sqsp_cmd_t;

	typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_IDLE} sqsp_phase_t;

endpackage : sqsp_pkg

//--- logic/sqsp_xfer_if.sv
`timescale 1ns/100ps
interface sqsp_xfer_if;
	logic        req_tgl;
	logic        req_we;
	logic [11:0] req_addr;
	logic [31:0] req_wdata;
	logic [31:0] rd_word;

	modport link (output req_tgl, output req_we, output req_addr, output req_wdata,
		input rd_word);
	modport sys (input req_tgl, input req_we, input req_addr, input req_wdata,
		output rd_word);
endinterface : sqsp_xfer_if

//--- logic/sqsp_xfer.sv
`timescale 1ns/100ps
module sqsp_xfer
	import sqsp_pkg::*;
(
	// System clock and reset.
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Requests from the link domain.
	sqsp_xfer_if.sys         x,
	// Register side.
	output logic             reg_req,
	output logic             reg_we,
	output logic [13:0]      reg_addr,
	output logic [31:0]      reg_wdata,
	input  wire logic        reg_ack,
	input  wire logic [31:0] reg_rdata
);

	logic tgl_s1_reg;
	logic tgl_s2_reg;
	logic tgl_seen_reg;
	logic busy_reg;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
		end else begin
			tgl_s1_reg <= x.req_tgl;
			tgl_s2_reg <= tgl_s1_reg;
		end
	end

	// The request bundle is held steady by the link side while the toggle settles.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tgl_seen_reg <= 1'b0;
			busy_reg     <= 1'b0;
			reg_req      <= 1'b0;
			reg_we       <= 1'b0;
			reg_addr     <= 14'h0000;
			reg_wdata    <= 32'h0000_0000;
		end else if (!busy_reg && (tgl_s2_reg != tgl_seen_reg)) begin
			tgl_seen_reg <= tgl_s2_reg;
			busy_reg     <= 1'b1;
			reg_req      <= 1'b1;
			reg_we       <= x.req_we;
			reg_addr     <= {x.req_addr, BYTE_LSBS};
			reg_wdata    <= x.req_wdata;
		end else begin
			reg_req <= 1'b0;
			if (reg_ack) begin
				busy_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			x.rd_word <= 32'h0000_0000;
		end else if (reg_ack && busy_reg && !reg_we) begin
			x.rd_word <= reg_rdata;
		end
	end

endmodule : sqsp_xfer

//--- logic/sqsp_top.sv
`timescale 1ns/100ps
module sqsp_top
	import sqsp_pkg::*;
(
	// System clock and reset.
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Serial link.
	input  wire logic        sck,
	input  wire logic        select_n,
	input  wire logic [3:0]  lane_i,
	output logic      [3:0]  lane_o,
	output logic      [3:0]  lane_oe,
	// Link mode, in the link clock domain.
	output logic             all_quad_mode,
	// Register side.
	output logic             reg_req,
	output logic             reg_we,
	output logic [13:0]      reg_addr,
	output logic [31:0]      reg_wdata,
	input  wire logic        reg_ack,
	input  wire logic [31:0] reg_rdata
);

	// Shifts a group of 1, 2 or 4 lane bits into the low end of a word.
	function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] grp,
		input logic [2:0] w);
		logic [31:0] r;
		r = {sh[30:0], grp[0]};
		unique case (w)
			LW2: r = {sh[29:0], grp[1:0]};
			LW4: r = {sh[27:0], grp};
			default: r = {sh[30:0], grp[0]};
		endcase
		return r;
	endfunction : shift_in

	// Puts byte 0 at the top so that a word leaves least significant byte first.
	function automatic logic [31:0] byte_swap(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : byte_swap

	// Steps a word address by one DWORD according to the step field.
	function automatic logic [11:0] step_addr(input logic [11:0] a, input logic [1:0] s);
		logic [11:0] r;
		r = a;
		unique case (s)
			STEP_INC: r = a + ADDR_STEP;
			STEP_DEC: r = a - ADDR_STEP;
			default: r = a;
		endcase
		return r;
	endfunction : step_addr

	// Picks the lanes that carry input for the given width.
	function automatic logic [3:0] lanes_in(input logic [3:0] l, input logic [2:0] w);
		logic [3:0] r;
		r = {3'h0, l[0]};
		unique case (w)
			LW2: r = {2'h0, l[1:0]};
			LW4: r = l;
			default: r = {3'h0, l[0]};
		endcase
		return r;
	endfunction : lanes_in

	// Decodes an instruction for the current protocol.
	function automatic sqsp_cmd_t decode(input logic [7:0] c, input logic q);
		sqsp_cmd_t d;
		d = '{1'b0, 1'b0, LW1, LW1, DUMMY_NONE};
		if (q) begin
			case (c)
				CMD_FAST_RD: d = '{1'b1, 1'b1, LW4, LW4, DUMMY_ALLQ};
				CMD_WRITE:   d = '{1'b1, 1'b0, LW4, LW4, DUMMY_NONE};
				default:     d = '{1'b0, 1'b0, LW1, LW1, DUMMY_NONE};
			endcase
		end else begin
			case (c)
				CMD_READ:         d = '{1'b1, 1'b1, LW1, LW1, DUMMY_NONE};
				CMD_FAST_RD:      d = '{1'b1, 1'b1, LW1, LW1, DUMMY_ONE};
				CMD_DUAL_OUT_RD:  d = '{1'b1, 1'b1, LW1, LW2, DUMMY_ONE};
				CMD_QUAD_OUT_RD:  d = '{1'b1, 1'b1, LW1, LW4, DUMMY_ONE};
				CMD_DUAL_IO_RD:   d = '{1'b1, 1'b1, LW2, LW2, DUMMY_DIO};
				CMD_QUAD_IO_RD:   d = '{1'b1, 1'b1, LW4, LW4, DUMMY_QIO};
				CMD_WRITE:        d = '{1'b1, 1'b0, LW1, LW1, DUMMY_NONE};
				CMD_DUAL_DATA_WR: d = '{1'b1, 1'b0, LW1, LW2, DUMMY_NONE};
				CMD_QUAD_DATA_WR: d = '{1'b1, 1'b0, LW1, LW4, DUMMY_NONE};
				CMD_DUAL_ADDR_WR: d = '{1'b1, 1'b0, LW2, LW2, DUMMY_NONE};
				CMD_QUAD_ADDR_WR: d = '{1'b1, 1'b0, LW4, LW4, DUMMY_NONE};
				default:          d = '{1'b0, 1'b0, LW1, LW1, DUMMY_NONE};
			endcase
		end
		return d;
	endfunction : decode

	sqsp_xfer_if xf ();

	// Link-side state; the frame state clears whenever select is high.
	logic        frame_rst_n;
	sqsp_phase_t phase_reg;
	sqsp_phase_t phase_next;
	logic [5:0]  cnt_reg;
	logic [5:0]  cnt_next;
	logic [5:0]  cnt_sum;
	logic [2:0]  cur_w;
	logic [3:0]  grp_in;
	logic [7:0]  cmd_sh_reg;
	logic [7:0]  cmd_next;
	logic [31:0] cmd_wide;
	sqsp_cmd_t   dec_reg;
	sqsp_cmd_t   dec_now;
	logic [15:0] addr_sh_reg;
	logic [15:0] addr_next;
	logic [31:0] addr_wide;
	logic [1:0]  step_reg;
	logic [11:0] word_addr_reg;
	logic [31:0] rx_sh_reg;
	logic [31:0] rx_next;
	logic [31:0] tx_sh_reg;
	logic        tx_on_reg;
	logic [3:0]  lane_o_reg;
	logic [3:0]  lane_oe_reg;
	logic        all_quad_mode_reg;
	logic        req_tgl_reg;
	logic        req_we_reg;
	logic [11:0] req_addr_reg;
	logic [31:0] req_wdata_reg;
	logic        cmd_done;
	logic        addr_done;
	logic        dummy_done;
	logic        word_done;
	logic        addr_fire;
	logic        start_tx;
	logic        tx_load;
	logic [11:0] fire_waddr;
	logic [1:0]  fire_step;
	logic [5:0]  dummy_bits;

	assign frame_rst_n = arst_n & ~select_n;

	// Width of the current phase and the bits it brings in.
	always_comb begin
		cur_w = LW1;
		unique case (phase_reg)
			PH_CMD:   cur_w = all_quad_mode_reg ? LW4 : LW1;
			PH_ADDR:  cur_w = dec_reg.aw;
			PH_DUMMY: cur_w = dec_reg.aw;
			PH_DATA:  cur_w = dec_reg.dw;
			PH_IDLE:  cur_w = LW1;
		endcase
	end

	assign grp_in     = lanes_in(lane_i, cur_w);
	assign cnt_sum    = cnt_reg + {3'h0, cur_w};
	assign cmd_wide   = shift_in({24'h00_0000, cmd_sh_reg}, grp_in, cur_w);
	assign cmd_next   = cmd_wide[7:0];
	assign addr_wide  = shift_in({16'h0000, addr_sh_reg}, grp_in, cur_w);
	assign addr_next  = addr_wide[15:0];
	assign rx_next    = shift_in(rx_sh_reg, grp_in, cur_w);
	assign dec_now    = decode(cmd_next, all_quad_mode_reg);
	assign dummy_bits = {dec_reg.dummy, 3'h0};

	assign cmd_done   = (phase_reg == PH_CMD) && (cnt_sum == CMD_BITS);
	assign addr_done  = (phase_reg == PH_ADDR) && (cnt_sum == ADDR_BITS);
	assign dummy_done = (phase_reg == PH_DUMMY) && (cnt_sum == dummy_bits);
	assign word_done  = (phase_reg == PH_DATA) && (cnt_sum == WORD_BITS);

	// The word address is known once bits 15:2 are in, so the first read starts early.
	assign addr_fire  = (phase_reg == PH_ADDR) && (cnt_reg < FIRE_BITS) &&
		(cnt_sum >= FIRE_BITS);
	assign fire_waddr = (cnt_sum == ADDR_BITS) ? addr_next[13:2] : addr_next[11:0];
	assign fire_step  = (cnt_sum == ADDR_BITS) ? addr_next[15:14] : addr_next[13:12];

	assign start_tx = dec_reg.rd && ((addr_done && (dec_reg.dummy == DUMMY_NONE)) ||
		dummy_done);
	assign tx_load  = dec_reg.rd && (start_tx || word_done);

	// Phase sequencing.
	always_comb begin
		phase_next = phase_reg;
		cnt_next   = cnt_sum;
		unique case (phase_reg)
			PH_CMD: begin
				if (cmd_done) begin
					cnt_next   = 6'h00;
					phase_next = dec_now.valid ? PH_ADDR : PH_IDLE;
				end
			end
			PH_ADDR: begin
				if (addr_done) begin
					cnt_next   = 6'h00;
					phase_next = (dec_reg.dummy != DUMMY_NONE) ? PH_DUMMY : PH_DATA;
				end
			end
			PH_DUMMY: begin
				if (dummy_done) begin
					cnt_next   = 6'h00;
					phase_next = PH_DATA;
				end
			end
			PH_DATA: begin
				if (word_done) begin
					cnt_next = 6'h00;
				end
			end
			PH_IDLE: begin
				cnt_next = cnt_reg;
			end
		endcase
	end

	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			phase_reg <= PH_CMD;
			cnt_reg   <= 6'h00;
		end else begin
			phase_reg <= phase_next;
			cnt_reg   <= cnt_next;
		end
	end

	// Instruction capture.
	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			cmd_sh_reg <= 8'h00;
			dec_reg    <= '{1'b0, 1'b0, LW1, LW1, DUMMY_NONE};
		end else if (phase_reg == PH_CMD) begin
			cmd_sh_reg <= cmd_next;
			if (cmd_done) begin
				dec_reg <= dec_now;
			end
		end
	end

	// Protocol mode survives across frames and changes only by instruction or by arst_n.
	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			all_quad_mode_reg <= 1'b0;
		end else if (cmd_done && !select_n) begin
			if (!all_quad_mode_reg && (cmd_next == CMD_ENTER_QUAD)) begin
				all_quad_mode_reg <= 1'b1;
			end else if (cmd_next == CMD_LEAVE_QUAD) begin
				all_quad_mode_reg <= 1'b0;
			end
		end
	end

	// Address capture and per-word stepping.
	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			addr_sh_reg   <= 16'h0000;
			step_reg      <= 2'h0;
			word_addr_reg <= 12'h000;
		end else begin
			if (phase_reg == PH_ADDR) begin
				addr_sh_reg <= addr_next;
			end
			if (addr_fire) begin
				word_addr_reg <= fire_waddr;
				step_reg      <= fire_step;
			end else if ((tx_load && !addr_done) || (word_done && !dec_reg.rd)) begin
				word_addr_reg <= step_addr(word_addr_reg, step_reg);
			end else if (tx_load && addr_done) begin
				word_addr_reg <= step_addr(word_addr_reg, step_reg);
			end
		end
	end

	// Write data assembly.
	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rx_sh_reg <= 32'h0000_0000;
		end else if ((phase_reg == PH_DATA) && !dec_reg.rd) begin
			rx_sh_reg <= rx_next;
		end
	end

	// Read data shifter; the word from the system side is taken at each word start.
	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			tx_sh_reg <= 32'h0000_0000;
			tx_on_reg <= 1'b0;
		end else if (tx_load) begin
			tx_sh_reg <= byte_swap(xf.rd_word);
			tx_on_reg <= 1'b1;
		end else if (tx_on_reg) begin
			tx_sh_reg <= shift_in(tx_sh_reg, 4'h0, cur_w);
		end
	end

	// Request bundle to the system side; held until the next toggle.
	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			req_tgl_reg   <= 1'b0;
			req_we_reg    <= 1'b0;
			req_addr_reg  <= 12'h000;
			req_wdata_reg <= 32'h0000_0000;
		end else if (addr_fire && dec_reg.rd) begin
			req_tgl_reg  <= ~req_tgl_reg;
			req_we_reg   <= 1'b0;
			req_addr_reg <= fire_waddr;
		end else if (tx_load) begin
			req_tgl_reg  <= ~req_tgl_reg;
			req_we_reg   <= 1'b0;
			req_addr_reg <= step_addr(word_addr_reg, step_reg);
		end else if (word_done && !dec_reg.rd) begin
			req_tgl_reg   <= ~req_tgl_reg;
			req_we_reg    <= 1'b1;
			req_addr_reg  <= word_addr_reg;
			req_wdata_reg <= byte_swap(rx_next);
		end
	end

	// Output lanes change only on the falling edge, and only in the data phase.
	always_ff @(negedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			lane_o_reg  <= 4'h0;
			lane_oe_reg <= 4'h0;
		end else if (tx_on_reg) begin
			unique case (dec_reg.dw)
				LW2: begin
					lane_o_reg  <= {2'h0, tx_sh_reg[31:30]};
					lane_oe_reg <= OE_W2;
				end
				LW4: begin
					lane_o_reg  <= tx_sh_reg[31:28];
					lane_oe_reg <= OE_W4;
				end
				default: begin
					lane_o_reg  <= {2'h0, tx_sh_reg[31], 1'b0};
					lane_oe_reg <= OE_W1;
				end
			endcase
		end else begin
			lane_o_reg  <= 4'h0;
			lane_oe_reg <= 4'h0;
		end
	end

	assign xf.req_tgl   = req_tgl_reg;
	assign xf.req_we    = req_we_reg;
	assign xf.req_addr  = req_addr_reg;
	assign xf.req_wdata = req_wdata_reg;

	assign lane_o        = lane_o_reg;
	assign lane_oe       = lane_oe_reg;
	assign all_quad_mode = all_quad_mode_reg;

	sqsp_xfer u_xfer (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.x         (xf.sys),
		.reg_req   (reg_req),
		.reg_we    (reg_we),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_ack   (reg_ack),
		.reg_rdata (reg_rdata)
	);

endmodule : sqsp_top

//--- sim/sqsp_top_props.sv
`timescale 1ns/100ps
module sqsp_top_props (
	// Clocks and reset.
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        sck,
	// Serial link.
	input wire logic        select_n,
	input wire logic [3:0]  lane_i,
	input wire logic [3:0]  lane_o,
	input wire logic [3:0]  lane_oe,
	input wire logic        all_quad_mode,
	// Register side.
	input wire logic        reg_req,
	input wire logic        reg_we,
	input wire logic [13:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_ack,
	input wire logic [31:0] reg_rdata
);
	logic pend_reg;

	// Marks a register access that still waits for its acknowledge.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			pend_reg <= 1'b0;
		else if (reg_req)
			pend_reg <= 1'b1;
		else if (reg_ack)
			pend_reg <= 1'b0;
	end

	a_idle_released: assert property (@(posedge mclk) disable iff (!arst_n)
		select_n |-> lane_oe == 4'h0) else $error("lanes driven while deselected");
	a_oe_width_legal: assert property (@(posedge mclk) disable iff (!arst_n)
		lane_oe inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("illegal lane enable");
	a_quad_all_lanes: assert property (@(posedge mclk) disable iff (!arst_n)
		all_quad_mode && lane_oe != 4'h0 |-> lane_oe == 4'hf) else $error("quad mode narrow");
	a_launch_on_fall: assert property (@(posedge mclk) disable iff (!arst_n || select_n)
		sck && $past(sck) |-> $stable(lane_o)) else $error("lanes moved while clock high");
	a_oe_holds_frame: assert property (@(posedge mclk) disable iff (!arst_n || select_n)
		$past(lane_oe) != 4'h0 |-> $stable(lane_oe)) else $error("lane enable dropped in frame");
	a_req_one_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
		reg_req |=> !reg_req) else $error("request longer than one cycle");
	a_addr_word_aligned: assert property (@(posedge mclk) disable iff (!arst_n)
		reg_req |-> reg_addr[1:0] == 2'h0) else $error("unaligned register address");
	a_fields_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		!reg_req |-> $stable(reg_addr) && $stable(reg_we)) else $error("fields moved");
	a_one_outstanding: assert property (@(posedge mclk) disable iff (!arst_n)
		reg_req |-> !pend_reg) else $error("request before acknowledge");
endmodule : sqsp_top_props

bind sqsp_top sqsp_top_props u_props (.mclk(mclk), .arst_n(arst_n), .sck(sck),
	.select_n(select_n), .lane_i(lane_i), .lane_o(lane_o), .lane_oe(lane_oe),
	.all_quad_mode(all_quad_mode), .reg_req(reg_req), .reg_we(reg_we),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata));

//--- sim/sqsp_host_model.sv
`timescale 1ns/100ps
module sqsp_host_model (
	// Link toward the device.
	output logic            sck,
	output logic            select_n,
	output logic      [3:0] lane_i,
	// Lanes launched by the device.
	input  wire logic [3:0] lane_o
);
	logic        idle;
	int          hp;
	logic [31:0] got [2];

	initial begin
		idle = 1'b0;
		hp = 16;
		sck = 1'b0;
		select_n = 1'b1;
		lane_i = 4'h0;
	end

	function automatic logic [31:0] bswap(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : bswap

	// Sends n bits msb first on w lanes and gathers what the device launched meanwhile.
	task automatic shift(input logic [31:0] v, input int n, input int w, output logic [31:0] r);
		logic [3:0] s;
		r = '0;
		for (int i = 0; i < n; i += w) begin
			sck = 1'b0;
			lane_i = v[31:28] >> (4 - w);
			v = v << w;
			#(hp);
			sck = 1'b1;
			s = (w == 1) ? {3'h0, lane_o[1]} : lane_o & 4'((1 << w) - 1);
			r = (r << w) | 32'(s);
			#(hp);
		end
	endtask : shift

	task automatic frame(input logic [7:0] cmd, input int cw, input logic [15:0] addr,
		input int aw, input int dc, input int dw, input logic [31:0] wd);
		logic [31:0] r;
		hp = (cmd == 8'h03) ? 17 : 16;
		sck = idle;
		#3;
		select_n = 1'b0;
		#(hp);
		shift({cmd, 24'h0}, 8, cw, r);
		if (cmd != 8'h38 && cmd != 8'hff) begin
			shift({addr, 16'h0}, 16, aw, r);
			shift(32'h0, dc * aw, aw, r);
			for (int k = 0; k < 2; k++) begin
				shift(bswap(wd + 32'(k)), 32, dw, r);
				got[k] = bswap(r);
			end
		end
		sck = idle;
		#(hp);
		select_n = 1'b1;
		lane_i = ~lane_i;
		#60;
	endtask : frame
endmodule : sqsp_host_model

//--- sim/serial_quad_slave_port_tb.sv
`timescale 1ns/100ps
module serial_quad_slave_port_tb
	import sqsp_pkg::*;
;

	typedef struct {
		logic [7:0]  cmd;
		int          cw;
		int          aw;
		int          dc;
		int          dw;
		logic        rd;
		logic [15:0] addr;
		logic [13:0] a2;
	} sqsp_row_t;

	logic        mclk;
	logic        arst_n;
	logic        reg_ack   = 1'b0;
	logic [31:0] reg_rdata = 32'h0000_0000;
	wire         sck;
	wire         select_n;
	wire  [3:0]  lane_i;
	wire  [3:0]  lane_o;
	wire  [3:0]  lane_oe;
	wire  [3:0]  lane_seen;
	wire         all_quad_mode;
	wire         reg_req;
	wire         reg_we;
	wire  [13:0] reg_addr;
	wire  [31:0] reg_wdata;
	int          failures;
	int          tests_run;
	int          nreq = 0;
	int          n;
	logic [45:0] wlog [$];

	sqsp_row_t rows [11] = '{
		'{CMD_READ,         1, 1, 0, 1, 1'b1, 16'h4010, 14'h0014},
		'{CMD_FAST_RD,      1, 1, 8, 1, 1'b1, 16'h8010, 14'h000c},
		'{CMD_DUAL_OUT_RD,  1, 1, 8, 2, 1'b1, 16'h0010, 14'h0010},
		'{CMD_QUAD_OUT_RD,  1, 1, 8, 4, 1'b1, 16'hc010, 14'h0010},
		'{CMD_DUAL_IO_RD,   1, 2, 8, 2, 1'b1, 16'h4ffc, 14'h1000},
		'{CMD_QUAD_IO_RD,   1, 4, 8, 4, 1'b1, 16'h8004, 14'h0000},
		'{CMD_WRITE,        1, 1, 0, 1, 1'b0, 16'h4020, 14'h0024},
		'{CMD_DUAL_DATA_WR, 1, 1, 0, 2, 1'b0, 16'h8020, 14'h001c},
		'{CMD_DUAL_ADDR_WR, 1, 2, 0, 2, 1'b0, 16'h0030, 14'h0030},
		'{CMD_QUAD_DATA_WR, 1, 1, 0, 4, 1'b0, 16'h4040, 14'h0044},
		'{CMD_QUAD_ADDR_WR, 1, 4, 0, 4, 1'b0, 16'h8050, 14'h004c}
	};

	sqsp_top dut_u (.mclk(mclk), .arst_n(arst_n), .sck(sck), .select_n(select_n),
		.lane_i(lane_i), .lane_o(lane_o), .lane_oe(lane_oe), .all_quad_mode(all_quad_mode),
		.reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata));
	sqsp_host_model host_u (.sck(sck), .select_n(select_n), .lane_i(lane_i), .lane_o(lane_seen));

	// A lane that the device does not enable reads back inverted, so a missing enable shows.
	assign lane_seen = lane_o ^ ~lane_oe;

	function automatic logic [31:0] rdf(input logic [13:0] a);
		return {a, ~a, 4'h9};
	endfunction : rdf

	// Register store stand-in: answers each request one cycle later.
	always @(posedge mclk) begin
		reg_ack <= reg_req;
		if (reg_req) begin
			reg_rdata <= rdf(reg_addr);
			nreq <= nreq + 1;
		end
		if (reg_req && reg_we)
			wlog.push_back({reg_addr, reg_wdata});
	end

	task automatic check(input logic [45:0] seen, input logic [45:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic run(input sqsp_row_t r);
		logic [13:0] a [2];
		a[0] = r.addr[13:0];
		a[1] = r.a2;
		wlog.delete();
		host_u.frame(r.cmd, r.cw, r.addr, r.aw, r.dc, r.dw, 32'h1e2d3c4b);
		for (int t = 0; t < 40 && !r.rd && wlog.size() < 2; t++)
			@(posedge mclk);
		for (int k = 0; k < 2; k++)
			if (r.rd)
				check(46'(host_u.got[k]), 46'(rdf(a[k])));
			else
				check(wlog.size() > k ? wlog[k] : '1, {a[k], 32'h1e2d3c4b + 32'(k)});
	endtask : run

	task automatic tally_and_finish();
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		#200000;
		failures++;
		tally_and_finish();
	end

	initial begin
		arst_n = 1'b0;
		failures = 0;
		tests_run = 0;
		repeat (5) @(posedge mclk);
		check(46'({lane_oe, lane_o, all_quad_mode, reg_req, reg_we, reg_addr}), 46'h0);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		foreach (rows[i])
			run(rows[i]);
		// All-quad protocol: enter, read, write, a refused code, then leave.
		host_u.frame(CMD_ENTER_QUAD, 1, 16'h0, 1, 0, 1, 32'h0);
		check(46'(all_quad_mode), 46'h1);
		run('{CMD_FAST_RD, 4, 4, 6, 4, 1'b1, 16'h4060, 14'h0064});
		run('{CMD_WRITE, 4, 4, 0, 4, 1'b0, 16'h8070, 14'h006c});
		n = nreq;
		host_u.frame(CMD_READ, 4, 16'h4000, 4, 0, 4, 32'h0);
		repeat (20) @(posedge mclk);
		check(46'(nreq - n), 46'h0);
		host_u.frame(CMD_LEAVE_QUAD, 4, 16'h0, 4, 0, 4, 32'h0);
		check(46'(all_quad_mode), 46'h0);
		// Reset in mid-run drops the protocol back to single lane and clears the outputs.
		host_u.frame(CMD_ENTER_QUAD, 1, 16'h0, 1, 0, 1, 32'h0);
		check(46'(all_quad_mode), 46'h1);
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		check(46'({lane_oe, lane_o, all_quad_mode, reg_req, reg_we, reg_addr}), 46'h0);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		// Serial clock idling high.
		host_u.idle = 1'b1;
		run('{CMD_WRITE, 1, 1, 0, 1, 1'b0, 16'h4080, 14'h0084});
		run('{CMD_FAST_RD, 1, 1, 8, 1, 1'b1, 16'h4010, 14'h0014});
		tally_and_finish();
	end
endmodule : serial_quad_slave_port_tb
